// ===== dv/dbc_host_model.sv
`default_nettype none
module dbc_host_model (
  input  wire logic        clk_sys_in,
  output var  logic        cmd_valid_out,
  output var  logic [7:0]  cmd_code_out,
  output var  logic [15:0] cmd_wdata_out
);
  timeunit 1ns / 1ps;
  initial
  begin
    cmd_valid_out = 1'b0;
    cmd_code_out  = 8'h00;
    cmd_wdata_out = 16'h0000;
  end
  task automatic send(input logic [7:0] c, input logic [15:0] d, input int gap);
    repeat (gap + 1) @(negedge clk_sys_in);
    cmd_valid_out = 1'b1;
    cmd_code_out  = c;
    cmd_wdata_out = d;
    @(negedge clk_sys_in);
    cmd_valid_out = 1'b0;
    // Released lines flip so a stale value never looks held
    cmd_code_out  = ~c;
    cmd_wdata_out = ~d;
  endtask
endmodule
`default_nettype wire

// ===== dv/dbc_regs_sva.sv
`default_nettype none
module dbc_regs_sva (
  input wire logic        clk_sys_in,
  input wire logic        rst_n_in,
  input wire logic        cmd_valid_in,
  input wire logic [7:0]  cmd_code_in,
  input wire logic [15:0] cmd_wdata_in,
  input wire logic        force_reset_wr_in,
  input wire logic [7:0]  force_reset_wdata_in,
  input wire logic        cpu_halted_in,
  input wire logic        cpu_insn_boundary_in,
  input wire logic        cpu_queue_end_tagged_in,
  input wire logic [15:0] rdata_out,
  input wire logic        rdata_valid_out,
  input wire logic        halt_permit_out,
  input wire logic        halt_request_out,
  input wire logic        debug_clock_select_out,
  input wire logic        mcu_reset_out
);
  timeunit 1ns / 1ps;
  default clocking @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);
  wire logic bg  = cmd_valid_in && cmd_code_in == 8'h90;
  wire logic wr  = cmd_valid_in && cmd_code_in == 8'hc4;
  wire logic rs  = cmd_valid_in && cmd_code_in == 8'he4;
  wire logic sel = cmd_wdata_in[3];
  // A breakpoint event in the same cycle may legally raise a halt
  wire logic quiet = !cpu_insn_boundary_in && !cpu_queue_end_tagged_in;
  sequence s_rst_pulse;
    mcu_reset_out [*8];
  endsequence
  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  read_answer_a: assert property (rs |=> rdata_valid_out)
    else $error("status read not answered");
  dv_zero_a: assert property (rs |=> !rdata_out[0])
    else $error("data valid failure bit set");
  permit_sticky_a: assert property (halt_permit_out |=> halt_permit_out)
    else $error("halt permit dropped");
  bg_refused_a: assert property (bg && !halt_permit_out && quiet |=> !halt_request_out)
    else $error("halt without permit");
  bg_taken_a: assert property (bg && halt_permit_out |=> halt_request_out)
    else $error("background not taken");
  halted_lock_a: assert property (wr && cpu_halted_in && !halt_permit_out |=> !halt_permit_out)
    else $error("permit written while halted");
  clk_select_a: assert property (wr |=> debug_clock_select_out == $past(sel))
    else $error("clock select not written");
  force_reset_a: assert property (force_reset_wr_in && force_reset_wdata_in[0] |=> s_rst_pulse)
    else $error("forced reset pulse short");
endmodule
bind dbc_debug_regs dbc_regs_sva dbc_regs_sva_i (.*);
`default_nettype wire

// ===== dv/tb.sv
`default_nettype none
module tb;
  timeunit 1ns / 1ps;
  logic        clk_sys_in  = 1'b0;
  logic        rst_n_in    = 1'b0;
  logic        halted      = 1'b0;
  logic        ws          = 1'b0;
  logic [15:0] addr        = 16'h0000;
  logic [7:0]  fr_data     = 8'h01;
  // Strobes: fetch, boundary, queue end, ws fail, mem start, fr read, user wr, fr wr
  logic [7:0]  ev_v        = 8'h00;
  wire  logic        cmd_valid;
  wire  logic [7:0]  cmd_code;
  wire  logic [15:0] cmd_wdata;
  logic [15:0] rdata;
  logic        rvalid, permit, hreq, tag, csel, mrst;
  int          n_mismatch  = 0;
  int          checks_done = 0;
  int          cyc         = 0;

  initial forever #2 clk_sys_in = ~clk_sys_in;
  // Far past the hundred or so cycles the scenarios need
  always @(posedge clk_sys_in)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  dbc_host_model dbc_host_model_i (.clk_sys_in(clk_sys_in), .cmd_valid_out(cmd_valid), .cmd_code_out(cmd_code),
    .cmd_wdata_out(cmd_wdata));
  dbc_debug_regs dbc_debug_regs_i (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .cmd_valid_in(cmd_valid),
    .cmd_code_in(cmd_code), .cmd_wdata_in(cmd_wdata), .force_reset_wr_in(ev_v[0]), .force_reset_wdata_in(fr_data),
    .force_reset_rd_in(ev_v[2]), .user_force_reset_wr_in(ev_v[1]), .cpu_halted_in(halted), .cpu_wait_stop_in(ws),
    .cpu_addr_in(addr), .cpu_opcode_fetch_in(ev_v[7]), .cpu_insn_boundary_in(ev_v[6]),
    .cpu_queue_end_tagged_in(ev_v[5]), .mem_cmd_ws_fail_in(ev_v[4]), .mem_cmd_start_in(ev_v[3]), .rdata_out(rdata),
    .rdata_valid_out(rvalid), .halt_permit_out(permit), .halt_request_out(hreq), .tag_opcode_out(tag),
    .debug_clock_select_out(csel), .mcu_reset_out(mrst));

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic st(input logic [7:0] e);
    dbc_host_model_i.send(8'he4, 16'h0000, 0);
    chk("status", {8'h00, e}, rdata);
  endtask
  task automatic wc(input logic [7:0] b);
    dbc_host_model_i.send(8'hc4, {8'h00, b}, 0);
  endtask
  task automatic bg;
    dbc_host_model_i.send(8'h90, 16'h0000, 0);
  endtask
  task automatic ev(input logic [7:0] v);
    @(negedge clk_sys_in);
    ev_v = v;
    @(negedge clk_sys_in);
    ev_v = 8'h00;
  endtask
  task tally_and_finish;
    $display("mismatches %0d of %0d checks", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_refuse;
    st(8'h00);
    chk("clk_sel", 16'h0000, 16'(csel));
    halted = 1'b1;
    st(8'h40);
    wc(8'h80);
    chk("permit", 16'h0000, 16'(permit));
    halted = 1'b0;
    bg();
    chk("halt_req", 16'h0000, 16'(hreq));
  endtask
  task automatic t_ctrl;
    dbc_host_model_i.send(8'hc4, 16'h00ff, 2);
    chk("permit", 16'h0001, 16'(permit));
    chk("clk_sel", 16'h0001, 16'(csel));
    st(8'hb8);
    wc(8'h00);
    st(8'h80);
    halted = 1'b1;
    wc(8'h08);
    chk("clk_sel", 16'h0001, 16'(csel));
    st(8'hc8);
    halted = 1'b0;
  endtask
  task automatic t_wait;
    ws = 1'b1;
    st(8'h8c);
    bg();
    chk("halt_req", 16'h0001, 16'(hreq));
    ws = 1'b0;
    halted = 1'b1;
    st(8'hcc);
    halted = 1'b0;
    ev(8'h10);
    st(8'h8a);
    ev(8'h08);
    st(8'h88);
  endtask
  task automatic t_bkpt;
    dbc_host_model_i.send(8'hc2, 16'ha5c3, 0);
    dbc_host_model_i.send(8'he2, 16'h0000, 0);
    chk("match", 16'ha5c3, rdata);
    addr = 16'ha5c3;
    wc(8'hb0);
    ev(8'h40);
    chk("halt_req", 16'h0001, 16'(hreq));
    wc(8'h90);
    ev(8'he0);
    chk("bkpt_off", 16'h0000, 16'(hreq | tag));
    wc(8'ha0);
    ev(8'h80);
    chk("tag", 16'h0001, 16'(tag));
    ev(8'h20);
    chk("halt_req", 16'h0001, 16'(hreq));
  endtask
  task automatic t_freset;
    int n = 0;
    ev(8'h04);
    chk("force_rd", 16'h0000, rdata);
    ev(8'h02);
    chk("user_wr", 16'h0000, 16'(mrst));
    ev(8'h01);
    repeat (10)
    begin
      if (mrst === 1'b1) n++;
      @(negedge clk_sys_in);
    end
    chk("reset_len", 16'h0008, 16'(n));
  endtask

  initial
  begin
    repeat (20) @(negedge clk_sys_in);
    rst_n_in = 1'b1;
    t_refuse();
    t_ctrl();
    t_wait();
    t_bkpt();
    t_freset();
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ===== hw/dbc_debug_regs.sv
// Operation
// R1 - Halt-permit bit 7: zero refuses halted mode, one allows halted commands.
// R2 - Halt-permit stays one once set until normal reset.
// R3 - Writes to halt-permit are ignored while halted.
// R4 - Halt-active, wait/stop and failure bits are read-only to control writes.
// R5 - Bit 6 reports halted state: zero running, one halted.
// R6 - Breakpoint enable clear: no breakpoint, select bit and match ignored.
// R7 - Force select set: address match forces halt at instruction boundary.
// R8 - Force select clear: match tags opcode; halt when tagged opcode executes.
// R9 - Bit 3 selects debug clock: zero alternate, one bus clock.
// R10 - Debug clock select writable any time, even halted.
// R11 - Bit 2 reads one in wait/stop or after background from wait/stop.
// R12 - Background command forces CPU out of wait/stop into halted mode.
// R13 - Host confirms halt-active before further commands after forcing halt.
// R14 - Bit 1 set when memory command fails due to concurrent wait/stop.
// R15 - Host recovers failure by background, retry, then restore and resume.
// R16 - Bit 0 data-valid failure unused: no slow memory exists.
// R17 - Data-valid failure flag always reads zero.
// R18 - Match register holds 16-bit address via dedicated serial commands.
// R19 - Registers lie outside CPU memory map; only serial commands reach them.
// R20 - Host sets breakpoints while halted, before running user code.
// R21 - Force-reset register writable only by serial memory writes.
// R22 - Force-reset register always reads zero.
// R23 - Writing one to force-reset bit performs full MCU reset.
// R24 - Background command halts only if halt-permit set, else ignored.
// R25 - Status read code e4 returns byte; write code c4 takes byte.
// R26 - Match read e2 and write c2 carry a 16-bit value.
`default_nettype none
module dbc_debug_regs (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  // Decoded serial command, one-cycle strobe
  input  wire logic        cmd_valid_in,
  input  wire logic [7:0]  cmd_code_in,
  input  wire logic [15:0] cmd_wdata_in,
  // Serial memory write aimed at the force-reset register
  input  wire logic        force_reset_wr_in,
  input  wire logic [7:0]  force_reset_wdata_in,
  // Force-reset read from a serial memory read
  input  wire logic        force_reset_rd_in,
  // User-program write to the force-reset register
  input  wire logic        user_force_reset_wr_in,
  // CPU and memory-command side
  input  wire logic        cpu_halted_in,
  input  wire logic        cpu_wait_stop_in,
  input  wire logic [15:0] cpu_addr_in,
  input  wire logic        cpu_opcode_fetch_in,
  input  wire logic        cpu_insn_boundary_in,
  input  wire logic        cpu_queue_end_tagged_in,
  input  wire logic        mem_cmd_ws_fail_in,
  input  wire logic        mem_cmd_start_in,
  // Outputs
  output logic [15:0] rdata_out,
  output logic        rdata_valid_out,
  output logic        halt_permit_out,
  output logic        halt_request_out,
  output logic        tag_opcode_out,
  output logic        debug_clock_select_out,
  output logic        mcu_reset_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        halt_permit;
    logic        halt_active;
    logic        bkpt_enable;
    logic        force_tag;
    logic        clk_select;
    logic        wait_stop;
    logic        bg_from_ws;
    logic        ws_failure;
    logic [15:0] match;
    logic [15:0] rdata;
    logic        rdata_valid;
    logic        halt_req;
    logic        tag;
    logic        mcu_reset;
    logic [3:0]  rst_cnt;
  } dbc_state_t;

  dbc_state_t st_q;
  dbc_state_t st_d;

  function automatic logic [7:0] dbc_status_byte(input dbc_state_t s);
    logic [7:0] b;
    b = 8'h00;
    b[dbc_pkg::POS_HALT_PERMIT] = s.halt_permit;
    b[dbc_pkg::POS_HALT_ACTIVE] = s.halt_active;
    b[dbc_pkg::POS_BKPT_ENABLE] = s.bkpt_enable;
    b[dbc_pkg::POS_FORCE_TAG]   = s.force_tag;
    b[dbc_pkg::POS_CLK_SELECT]  = s.clk_select;
    b[dbc_pkg::POS_WAIT_STOP]   = s.wait_stop | s.bg_from_ws;
    b[dbc_pkg::POS_WS_FAILURE]  = s.ws_failure;
    // R16 no slow memory
    // R17 unused flag zero
    b[dbc_pkg::POS_DV_FAILURE]  = 1'b0;
    return b;
  endfunction

  logic addr_hit;
  assign addr_hit = (cpu_addr_in == st_q.match);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_d             = st_q;
    st_d.rdata_valid = 1'b0;
    st_d.halt_req    = 1'b0;
    st_d.tag         = 1'b0;
    // R5 mirror halted state
    st_d.halt_active = cpu_halted_in;
    // R11 wait/stop tracking
    st_d.wait_stop   = cpu_wait_stop_in;
    if (!cpu_halted_in && !st_q.halt_req)
    begin
      st_d.bg_from_ws = 1'b0;
    end
    // R14 failure flag, set wins over a new command clearing it
    if (mem_cmd_start_in)
    begin
      st_d.ws_failure = 1'b0;
    end
    if (mem_cmd_ws_fail_in)
    begin
      st_d.ws_failure = 1'b1;
    end

    // R6 breakpoint gated by enable
    if (st_q.bkpt_enable && addr_hit)
    begin
      // R7 forced breakpoint
      if (st_q.force_tag)
      begin
        if (cpu_insn_boundary_in)
        begin
          st_d.halt_req = 1'b1;
        end
      end
      // R8 tag opcode
      else if (cpu_opcode_fetch_in)
      begin
        st_d.tag = 1'b1;
      end
    end
    // R8 tagged opcode halts
    if (cpu_queue_end_tagged_in && st_q.bkpt_enable && !st_q.force_tag)
    begin
      st_d.halt_req = 1'b1;
    end

    if (cmd_valid_in)
    begin
      // R24 background honoured only when permitted
      if (cmd_code_in == dbc_pkg::CMD_BACKGROUND)
      begin
        // R1 refuse halt without permit
        if (st_q.halt_permit)
        begin
          // R12 background leaves wait/stop
          st_d.halt_req = 1'b1;
          if (cpu_wait_stop_in)
          begin
            st_d.bg_from_ws = 1'b1;
          end
        end
      end
      // R25 status read
      else if (cmd_code_in == dbc_pkg::CMD_READ_STATUS)
      begin
        st_d.rdata       = {8'h00, dbc_status_byte(st_q)};
        st_d.rdata_valid = 1'b1;
      end
      // R25 control write
      else if (cmd_code_in == dbc_pkg::CMD_WRITE_CTRL)
      begin
        // R2 R3 permit sticky and locked while halted
        if (!cpu_halted_in && cmd_wdata_in[dbc_pkg::POS_HALT_PERMIT])
        begin
          st_d.halt_permit = 1'b1;
        end
        st_d.bkpt_enable = cmd_wdata_in[dbc_pkg::POS_BKPT_ENABLE];
        st_d.force_tag   = cmd_wdata_in[dbc_pkg::POS_FORCE_TAG];
        // R10 R9 clock select always writable
        st_d.clk_select  = cmd_wdata_in[dbc_pkg::POS_CLK_SELECT];
        // R4 status bits untouched here
      end
      // R26 match read
      else if (cmd_code_in == dbc_pkg::CMD_MATCH_READ)
      begin
        st_d.rdata       = st_q.match;
        st_d.rdata_valid = 1'b1;
      end
      // R26 R18 match write
      else if (cmd_code_in == dbc_pkg::CMD_MATCH_WRITE)
      begin
        st_d.match = cmd_wdata_in;
      end
    end

    // R22 force-reset reads zero
    if (force_reset_rd_in)
    begin
      st_d.rdata       = {8'h00, dbc_pkg::FORCE_RST_RD};
      st_d.rdata_valid = 1'b1;
    end

    // R21 R23 only serial writes may reset; user writes dropped
    if (force_reset_wr_in && force_reset_wdata_in[dbc_pkg::POS_FORCE_RESET])
    begin
      st_d.mcu_reset = 1'b1;
      st_d.rst_cnt   = dbc_pkg::RST_PULSE_CYC;
    end
    else if (st_q.rst_cnt != 4'h0)
    begin
      st_d.rst_cnt = st_q.rst_cnt - 4'h1;
      if (st_q.rst_cnt == 4'h1)
      begin
        st_d.mcu_reset = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Reset pulse is generated here but our own reset comes from rst_n_in,
  // not from mcu_reset_out, so this block is not cleared by the reset it causes.
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      st_q             <= '0;
      st_q.halt_permit <= dbc_pkg::RST_CTRL_BIT;
      st_q.clk_select  <= dbc_pkg::RST_CTRL_BIT;
      st_q.match       <= dbc_pkg::RST_MATCH;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // R19 no memory-map access path exists
  assign rdata_out              = st_q.rdata;
  assign rdata_valid_out        = st_q.rdata_valid;
  assign halt_permit_out        = st_q.halt_permit;
  assign halt_request_out       = st_q.halt_req;
  assign tag_opcode_out         = st_q.tag;
  assign debug_clock_select_out = st_q.clk_select;
  assign mcu_reset_out          = st_q.mcu_reset;

  logic unused_user_wr;
  assign unused_user_wr = user_force_reset_wr_in;

endmodule
`default_nettype wire

// ===== hw/dbc_pkg.sv
`default_nettype none
package dbc_pkg;

  // ----------------------------------------------------------------
  // Serial command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_BACKGROUND  = 8'h90;
  localparam logic [7:0] CMD_READ_STATUS = 8'he4;
  localparam logic [7:0] CMD_WRITE_CTRL  = 8'hc4;
  localparam logic [7:0] CMD_MATCH_READ  = 8'he2;
  localparam logic [7:0] CMD_MATCH_WRITE = 8'hc2;

  // ----------------------------------------------------------------
  // Status/control field positions
  // ----------------------------------------------------------------
  localparam int POS_HALT_PERMIT  = 7;
  localparam int POS_HALT_ACTIVE  = 6;
  localparam int POS_BKPT_ENABLE  = 5;
  localparam int POS_FORCE_TAG    = 4;
  localparam int POS_CLK_SELECT   = 3;
  localparam int POS_WAIT_STOP    = 2;
  localparam int POS_WS_FAILURE   = 1;
  localparam int POS_DV_FAILURE   = 0;
  localparam int POS_FORCE_RESET  = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic        RST_CTRL_BIT  = 1'b0;
  localparam logic [15:0] RST_MATCH     = 16'h0000;
  localparam logic [7:0]  FORCE_RST_RD  = 8'h00;

  // Forced MCU reset pulse length in core clocks
  localparam logic [3:0]  RST_PULSE_CYC = 4'h8;

endpackage
`default_nettype wire
